// ===== pkg/port_e_pkg.sv
package port_e_pkg;
  // register offsets, index form (printed offsets are not multiples of 4)
  localparam logic [7:0] DIR_REG_IDX     = 8'h01;
  localparam logic [7:0] DATA_REG_IDX    = 8'h0e;
  localparam logic [7:0] CFG_REG_IDX     = 8'h20;
  localparam logic [7:0] WAKE_REG_IDX    = 8'h21;
  localparam logic [7:0] STAT_REG_IDX    = 8'h22;
  // option and status register field positions
  localparam int CFG_CMP1_BIT  = 0;
  localparam int CFG_CMP2_BIT  = 1;
  localparam int CFG_AMP_BIT   = 2;
  localparam int CFG_BIT1_ZERO_READ_OPTION_BIT  = 3;
  localparam int CFG_BIT3_ZERO_READ_OPTION_BIT  = 4;
  localparam int CFG_BIDIR_BIT = 5;
  localparam int STAT_HALT_BIT = 0;
  localparam int STAT_WAKE_BIT = 1;
  // reset values
  localparam logic [3:0] DIR_RESET  = 4'h0;
  localparam logic [3:0] DATA_RESET = 4'h0;
  localparam logic [5:0] CFG_RESET  = 6'h00;
  localparam logic [3:0] WAKE_RESET = 4'h0;
  // port mode derived from the options
  typedef enum logic [1:0] {
    MODE_PLAIN,
    MODE_CMP,
    MODE_CMP_AMP,
    MODE_AMP
  } port_mode_t;
endpackage : port_e_pkg

// ===== pkg/port_e_read_if.sv
// read-source selection bundle between the register block and the mux
interface port_e_read_if;
  logic [3:0] pad;
  logic [3:0] latch;
  logic [3:0] dir;
  logic [5:0] cfg;
  logic       cmp1_out;
  logic       cmp2_out;
  logic [3:0] rd_value;
  modport ctrl (output pad, latch, dir, cfg, cmp1_out, cmp2_out,
                input rd_value);
  modport mux  (input pad, latch, dir, cfg, cmp1_out, cmp2_out,
                output rd_value);
endinterface : port_e_read_if

// ===== rtl/port_e_read_mux.sv
module port_e_read_mux
  import port_e_pkg::*;
(
  port_e_read_if.mux rif
);
  logic cmp1;
  logic cmp2;
  logic amp;
  logic any_cmp;
  logic [3:0] base;

  // option decode
  assign cmp1    = rif.cfg[CFG_CMP1_BIT];
  assign cmp2    = rif.cfg[CFG_CMP2_BIT];
  assign amp     = rif.cfg[CFG_AMP_BIT];
  assign any_cmp = cmp1 | cmp2;

  // output bits read their latch, input bits read the pad
  assign base = (rif.dir & rif.latch) | (~rif.dir & rif.pad);

  // per-bit source chosen from static options at read time [R14]
  always_comb begin
    rif.rd_value = base; // [R9]
    if (cmp1) begin
      rif.rd_value[0] = rif.cmp1_out; // [R1] [R10]
    end
    if (cmp2) begin
      rif.rd_value[2] = rif.cmp2_out; // [R2] [R10]
    end
    if (any_cmp && rif.cfg[CFG_BIT1_ZERO_READ_OPTION_BIT]) begin
      rif.rd_value[1] = 1'b0; // [R3]
    end else begin
      rif.rd_value[1] = base[1]; // [R4]
    end
    if (any_cmp && rif.cfg[CFG_BIT3_ZERO_READ_OPTION_BIT]) begin
      rif.rd_value[3] = 1'b0; // [R5]
    end else begin
      rif.rd_value[3] = base[3]; // [R6]
    end
    if (amp && cmp1 && !cmp2) begin
      rif.rd_value[3:2] = 2'h0; // [R7]
    end
  end
endmodule : port_e_read_mux

// ===== rtl/port_e_comparator_read_mux.sv
// Contract
// R1 - with comparator one enabled, data bit 0 reads comparator one's output.
// R2 - with comparator two enabled, data bit 2 reads comparator two's output.
// R3 - with a comparator on and bit-1 zero-read set, data bit 1 reads 0.
// R4 - with comparator one on and bit-1 zero-read clear, bit 1 reads the pin.
// R5 - with a comparator on and bit-3 zero-read set, data bit 3 reads 0.
// R6 - with comparator two on and bit-3 zero-read clear, bit 3 reads the pin.
// R7 - in comparator-plus-amplifier mode, data bits 2 and 3 read 0.
// R8 - software never sets the amplifier mode together with comparator two.
// R9 - with no comparator or amplifier, the port is plain I/O.
// R10 - each comparator is enabled on its own, the rest stays plain I/O.
// R11 - without the bidirectional option the pins are inputs only.
// R12 - each pin has its own wake enable; only enabled pins wake from halt.
// R13 - with bidirectional on, direction bit 1 drives, 0 inputs, reset 0.
// R14 - read source is chosen combinationally and never alters the latch.
module port_e_comparator_read_mux
  import port_e_pkg::*;
(
  input  wire logic       MCLK,
  input  wire logic       RST_B,
  input  wire logic       CE,
  input  wire logic [7:0] ADDR,
  input  wire logic [3:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [3:0] RDATA,
  input  wire logic [3:0] PE_IN,
  output logic      [3:0] PE_OUT,
  output logic      [3:0] PE_OE,
  input  wire logic       CMP1_IN,
  input  wire logic       CMP2_IN,
  input  wire logic       HALT,
  output logic            WAKE,
  output logic [1:0]      MODE
);
  logic       rst_meta_r;
  logic       rst_sync_r;
  logic       rst_n;
  logic [3:0] pad_meta_r;
  logic [3:0] pad_r;
  logic [3:0] pad_prev_r;
  logic [1:0] cmp_meta_r;
  logic [1:0] cmp_r;
  logic [3:0] dir_r;
  logic [3:0] latch_r;
  logic [5:0] cfg_r;
  logic [3:0] wake_en_r;
  logic       halt_meta_r;
  logic       halt_r;
  logic [3:0] eff_dir;
  logic [3:0] rdata_nxt;
  logic [3:0] rise;
  port_mode_t mode;
  logic       wr_dir;
  logic       wr_data;
  logic       wr_cfg;
  logic       wr_cfg_hi;
  logic       wr_wake;

  port_e_read_if rif ();

  // true when the bus addresses the given register index
  function automatic logic hit(input logic [7:0] idx);
    return ADDR == idx;
  endfunction : hit

  // write enables, gated by the clock enable so a frozen block ignores writes
  assign wr_dir    = CE && WR && hit(DIR_REG_IDX);
  assign wr_data   = CE && WR && hit(DATA_REG_IDX);
  assign wr_cfg    = CE && WR && hit(CFG_REG_IDX);
  assign wr_cfg_hi = CE && WR && hit(CFG_REG_IDX + 8'h10);
  assign wr_wake   = CE && WR && hit(WAKE_REG_IDX);

  // reset release through two flip-flops
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_n = rst_sync_r;

  // pin and comparator synchronisers
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      pad_meta_r  <= 4'h0;
      pad_r       <= 4'h0;
      pad_prev_r  <= 4'h0;
      cmp_meta_r  <= 2'h0;
      cmp_r       <= 2'h0;
      halt_meta_r <= 1'b0;
      halt_r      <= 1'b0;
    end else if (CE) begin
      pad_meta_r  <= PE_IN;
      pad_r       <= pad_meta_r;
      pad_prev_r  <= pad_r;
      cmp_meta_r  <= {CMP2_IN, CMP1_IN};
      cmp_r       <= cmp_meta_r;
      halt_meta_r <= HALT;
      halt_r      <= halt_meta_r;
    end
  end

  // direction register write
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      dir_r <= DIR_RESET; // [R13]
    end else if (wr_dir) begin
      dir_r <= WDATA; // [R13]
    end
  end

  // output latch write; reads never touch it
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      latch_r <= DATA_RESET;
    end else if (wr_data) begin
      latch_r <= WDATA; // [R14]
    end
  end

  // option register; the low index also loads the upper pair, so software
  // writes the upper index afterwards to set the bit-3 zero-read and bidir bits
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= CFG_RESET;
    end else if (wr_cfg) begin
      cfg_r <= {WDATA[1:0], WDATA[3:0]};
    end else if (wr_cfg_hi) begin
      cfg_r[5:4] <= WDATA[1:0];
    end
  end

  // per-pin wake enables
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      wake_en_r <= WAKE_RESET;
    end else if (wr_wake) begin
      wake_en_r <= WDATA; // [R12]
    end
  end

  // pins drive only with the bidirectional option set
  assign eff_dir = cfg_r[CFG_BIDIR_BIT] ? dir_r : 4'h0; // [R11] [R13]
  assign PE_OE   = eff_dir; // [R11]
  assign PE_OUT  = latch_r;

  // rising edge on an enabled input pin wakes from halt
  assign rise = pad_r & ~pad_prev_r;
  assign WAKE = halt_r & |(rise & wake_en_r & ~eff_dir); // [R12]

  // mode summary for status
  always_comb begin
    mode = MODE_PLAIN;
    if (cfg_r[CFG_AMP_BIT] && cfg_r[CFG_CMP1_BIT]) begin
      mode = MODE_CMP_AMP; // [R8]
    end else if (cfg_r[CFG_AMP_BIT]) begin
      mode = MODE_AMP;
    end else if (cfg_r[CFG_CMP1_BIT] || cfg_r[CFG_CMP2_BIT]) begin
      mode = MODE_CMP;
    end
  end
  assign MODE = mode;

  // feed the read mux
  assign rif.pad      = pad_r;
  assign rif.latch    = latch_r;
  assign rif.dir      = eff_dir;
  assign rif.cfg      = cfg_r;
  assign rif.cmp1_out = cmp_r[0];
  assign rif.cmp2_out = cmp_r[1];

  port_e_read_mux u_mux (
    .rif (rif.mux)
  );

  // read data decode
  always_comb begin
    rdata_nxt = 4'h0;
    case (ADDR)
      DIR_REG_IDX:  rdata_nxt = dir_r;
      DATA_REG_IDX: rdata_nxt = rif.rd_value; // [R1] [R2] [R14]
      CFG_REG_IDX:  rdata_nxt = cfg_r[3:0];
      WAKE_REG_IDX: rdata_nxt = wake_en_r;
      STAT_REG_IDX: rdata_nxt = {2'h0, WAKE, halt_r};
      default:      rdata_nxt = 4'h0;
    endcase
  end

  // read data registered one cycle after the strobe
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= 4'h0;
    end else if (CE) begin
      RDATA <= RD ? rdata_nxt : 4'h0;
    end
  end
endmodule : port_e_comparator_read_mux

// ===== verification/port_e_read_asserts.sv
module port_e_read_asserts
  import port_e_pkg::*;
(
  input wire logic       MCLK,
  input wire logic       RST_B,
  input wire logic [7:0] ADDR,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [3:0] RDATA,
  input wire logic [3:0] PE_IN,
  input wire logic [3:0] PE_OUT,
  input wire logic [3:0] PE_OE,
  input wire logic       CMP1_IN,
  input wire logic       HALT,
  input wire logic       WAKE,
  input wire logic [1:0] MODE
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  logic data_rd;
  // read of the port data index
  assign data_rd = RD && ADDR == DATA_REG_IDX;
  rdata_idle_a:
    assert property (!RD |=> RDATA == 4'h0) else $error("stray read data");
  plain_read_a:
    assert property (data_rd && MODE == MODE_PLAIN && PE_OE == 4'h0
      |=> RDATA == $past(PE_IN, 3)) else $error("plain read wrong");
  amp_read_a:
    assert property (data_rd && MODE == MODE_CMP_AMP
      |=> RDATA[3:2] == 2'b00 && RDATA[0] == $past(CMP1_IN, 3))
      else $error("amp mode read wrong");
  dir_read_a:
    assert property (RD && ADDR == DIR_REG_IDX
      |=> (RDATA & $past(PE_OE)) == $past(PE_OE)) else $error("dir wrong");
  oe_cause_a:
    assert property ($changed(PE_OE) |-> $past(WR)) else $error("oe moved");
  latch_cause_a:
    assert property ($changed(PE_OUT) |-> $past(WR)) else $error("latch moved");
  latch_addr_a:
    assert property ($changed(PE_OUT) |-> $past(ADDR) == DATA_REG_IDX)
      else $error("latch written from wrong index");
  wake_halt_a:
    assert property (WAKE |-> $past(HALT, 2)) else $error("wake while running");
endmodule : port_e_read_asserts

bind port_e_comparator_read_mux port_e_read_asserts chk_i (.*);

// ===== verification/test_port_e_comparator_read_mux.sv
module test_port_e_comparator_read_mux
  import port_e_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       MCLK = 0, RST_B = 0, WR = 0, RD = 0, HALT = 0;
  logic       CMP1_IN = 0, CMP2_IN = 0, WAKE, CE = 1;
  logic [7:0] ADDR = 8'h00;
  logic [3:0] WDATA = 4'h0, PE_IN = 4'h0, RDATA, PE_OUT, PE_OE, v;
  logic [1:0] MODE;
  int         fails = 0, cmp_count = 0;
  port_e_comparator_read_mux dut (.MCLK(MCLK), .RST_B(RST_B), .CE(CE),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .PE_IN(PE_IN), .PE_OUT(PE_OUT), .PE_OE(PE_OE), .CMP1_IN(CMP1_IN),
    .CMP2_IN(CMP2_IN), .HALT(HALT), .WAKE(WAKE), .MODE(MODE));
  // 25 ns clock
  initial begin
    forever #12.5 MCLK = ~MCLK;
  end
  task automatic chk(input string what, input logic [3:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    @(posedge MCLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge MCLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge MCLK);
    RD <= 1'b0;
    @(negedge MCLK);
    v = RDATA;
  endtask : rd
  // options, pads and comparators set, then one data read
  task automatic mux(input logic [3:0] c20, c30, pe, input logic c1, c2,
                     input logic [3:0] exp);
    PE_IN <= pe;
    CMP1_IN <= c1;
    CMP2_IN <= c2;
    wr(CFG_REG_IDX, c20);
    wr(8'h30, c30);
    repeat (4) @(posedge MCLK);
    rd(DATA_REG_IDX);
    chk("data", v, exp);
  endtask : mux
  // bounded watch of the wake level after a pad change
  task automatic watch(input logic [3:0] pe, input logic exp);
    logic hit;
    hit = 1'b0;
    PE_IN <= pe;
    repeat (8) begin
      @(negedge MCLK);
      if (WAKE === 1'b1) hit = 1'b1;
    end
    chk("wake", {3'h0, hit}, {3'h0, exp});
  endtask : watch
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  // main sequence
  initial begin
    repeat (3) @(posedge MCLK);
    RST_B <= 1'b1;
    repeat (3) @(posedge MCLK);
    rd(DIR_REG_IDX);
    chk("dir", v, DIR_RESET);
    mux(4'h8, 4'h1, 4'ha, 1'b1, 1'b1, 4'ha);
    chk("mode", {2'h0, MODE}, {2'h0, MODE_PLAIN});
    mux(4'hc, 4'h1, 4'hf, 1'b0, 1'b0, 4'hf);
    chk("mode", {2'h0, MODE}, {2'h0, MODE_AMP});
    mux(4'h1, 4'h0, 4'hf, 1'b0, 1'b0, 4'he);
    mux(4'h9, 4'h0, 4'hf, 1'b1, 1'b0, 4'hd);
    mux(4'h2, 4'h1, 4'hf, 1'b0, 1'b0, 4'h3);
    mux(4'h2, 4'h0, 4'h8, 1'b1, 1'b1, 4'hc);
    mux(4'h5, 4'h0, 4'hf, 1'b1, 1'b1, 4'h3);
    chk("mode", {2'h0, MODE}, {2'h0, MODE_CMP_AMP});
    mux(4'hd, 4'h0, 4'hf, 1'b0, 1'b1, 4'h0);
    $display("read source test done");
    wr(DIR_REG_IDX, 4'h5);
    wr(DATA_REG_IDX, 4'h6);
    @(negedge MCLK);
    chk("oe", PE_OE, 4'h0);
    wr(CFG_REG_IDX, 4'h0);
    wr(8'h30, 4'h2);
    @(negedge MCLK);
    chk("oe", PE_OE, 4'h5);
    chk("out", PE_OUT, 4'h6);
    CE <= 1'b0;
    wr(DATA_REG_IDX, 4'h9);
    @(posedge MCLK);
    CE <= 1'b1;
    @(negedge MCLK);
    chk("frozen", PE_OUT, 4'h6);
    PE_IN <= 4'h8;
    repeat (4) @(posedge MCLK);
    rd(DATA_REG_IDX);
    chk("data", v, 4'hc);
    rd(DIR_REG_IDX);
    chk("dir", v, 4'h5);
    $display("direction test done");
    wr(WAKE_REG_IDX, 4'h2);
    HALT <= 1'b1;
    PE_IN <= 4'h0;
    repeat (4) @(posedge MCLK);
    watch(4'h1, 1'b0);
    watch(4'h3, 1'b1);
    $display("wake test done");
    finish_test();
  end
endmodule : test_port_e_comparator_read_mux
